// >>> piy_pkg.sv
// constants for the port-input and y-increment decoder
package piy_pkg;
    localparam int          PIY_INSN_W    = 10;
    localparam int          PIY_NIB_W     = 4;
    localparam logic [9:0]  PIY_OP_RDP0   = 10'h0260;
    localparam logic [9:0]  PIY_OP_RDP1   = 10'h0261;
    localparam logic [9:0]  PIY_OP_RDP2   = 10'h0262;
    localparam logic [9:0]  PIY_OP_RDP3   = 10'h0263;
    localparam logic [9:0]  PIY_OP_RDP4   = 10'h0264;
    localparam logic [9:0]  PIY_OP_INCY   = 10'h0013;
    localparam logic [3:0]  PIY_ACC_RST   = 4'h0;
    localparam logic [3:0]  PIY_Y_RST     = 4'h0;
    localparam logic [3:0]  PIY_Y_ONE     = 4'h1;
    localparam logic [3:0]  PIY_Y_ZERO    = 4'h0;
endpackage

// >>> piy_decoder.sv
// execution of port-input instructions and the y-pointer increment
//
// Contract
// - port zero input copied into accumulator
// - port one input loaded into accumulator
// - port two input placed into accumulator
// - port four input written into accumulator
// - increment y by one, wrap at fifteen
// - y result zero skips next instruction
// - nonzero y result executes next instruction
`timescale 1ns/100ps
`default_nettype none
module piy_decoder
    import piy_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  insn_valid_i,
    input  wire logic [PIY_INSN_W-1:0] insn_i,
    input  wire logic [PIY_NIB_W-1:0]  input_port_zero_i,
    input  wire logic [PIY_NIB_W-1:0]  input_port_one_i,
    input  wire logic [PIY_NIB_W-1:0]  input_port_two_i,
    input  wire logic [PIY_NIB_W-1:0]  input_port_three_i,
    input  wire logic [PIY_NIB_W-1:0]  input_port_four_i,
    output logic      [PIY_NIB_W-1:0]  acc_o,
    output logic      [PIY_NIB_W-1:0]  y_ptr_o,
    output logic                       skip_o
);
    logic [PIY_NIB_W-1:0] acc_ff;
    logic [PIY_NIB_W-1:0] nxt_acc;
    logic [PIY_NIB_W-1:0] y_ff;
    logic [PIY_NIB_W-1:0] nxt_y;
    logic [PIY_NIB_W-1:0] y_inc;
    logic                 skip_ff;
    logic                 nxt_skip;
    logic                 exec;
    logic                 wrap;
    logic                 is_rd0;
    logic                 is_rd1;
    logic                 is_rd2;
    logic                 is_rd3;
    logic                 is_rd4;
    logic                 is_incy;
    logic                 is_read;

    // a skipped slot is consumed without effect, like a no-op cycle
    assign exec  = insn_valid_i && !skip_ff;
    assign y_inc = y_ff + PIY_Y_ONE;
    // judged on the new value, so fifteen plus one counts as zero
    assign wrap  = (y_inc == PIY_Y_ZERO);

    // opcode decode; qualified by exec wherever it takes effect
    assign is_rd0  = (insn_i == PIY_OP_RDP0);
    assign is_rd1  = (insn_i == PIY_OP_RDP1);
    assign is_rd2  = (insn_i == PIY_OP_RDP2);
    assign is_rd3  = (insn_i == PIY_OP_RDP3);
    assign is_rd4  = (insn_i == PIY_OP_RDP4);
    assign is_incy = (insn_i == PIY_OP_INCY);
    assign is_read = is_rd0 || is_rd1 || is_rd2 || is_rd3 || is_rd4;

    // accumulator: written only by the port reads
    always_comb begin
        nxt_acc = acc_ff;
        if (exec) begin
            unique case (insn_i)
                PIY_OP_RDP0: nxt_acc = input_port_zero_i;
                PIY_OP_RDP1: nxt_acc = input_port_one_i;
                PIY_OP_RDP2: nxt_acc = input_port_two_i;
                PIY_OP_RDP3: nxt_acc = input_port_three_i;
                PIY_OP_RDP4: nxt_acc = input_port_four_i;
                // other opcodes belong to the rest of the core
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            acc_ff <= PIY_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // y pointer: four bits, so the carry out of fifteen is simply lost
    always_comb begin
        nxt_y = y_ff;
        if (exec && is_incy) begin
            nxt_y = y_inc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            y_ff <= PIY_Y_RST;
        end else begin
            y_ff <= nxt_y;
        end
    end

    // any valid slot retires a pending skip; only a wrap arms a new one
    always_comb begin
        nxt_skip = skip_ff;
        if (insn_valid_i) begin
            nxt_skip = 1'b0;
        end
        if (exec && is_incy) begin
            nxt_skip = wrap;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            skip_ff <= 1'b0;
        end else begin
            skip_ff <= nxt_skip;
        end
    end

    assign acc_o   = acc_ff;
    assign y_ptr_o = y_ff;
    assign skip_o  = skip_ff;

    AST_RDP0: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP0 |=> acc_o == $past(input_port_zero_i))
        else $error("port zero not in accumulator");

    AST_RDP1: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP1 |=> acc_o == $past(input_port_one_i))
        else $error("port one not in accumulator");

    AST_RDP2: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP2 |=> acc_o == $past(input_port_two_i))
        else $error("port two not in accumulator");

    AST_RDP3: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP3 |=> acc_o == $past(input_port_three_i))
        else $error("port three not in accumulator");

    AST_RDP4: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP4 |=> acc_o == $past(input_port_four_i))
        else $error("port four not in accumulator");

    AST_INCY: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_INCY |=> y_ptr_o == $past(y_ptr_o) + PIY_Y_ONE)
        else $error("y pointer not incremented");

    AST_SKIP_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_INCY && y_ptr_o == 4'hF
        ##1 insn_valid_i |-> ##1 acc_o == $past(acc_o) && y_ptr_o == $past(y_ptr_o))
        else $error("instruction after wrap not skipped");

    AST_NO_SKIP: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_INCY && y_ptr_o != 4'hF |=> !skip_o)
        else $error("skip set on nonzero result");

    AST_ACC_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !exec |=> $stable(acc_o))
        else $error("accumulator changed without instruction");

    AST_SKIP_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && is_incy && y_ptr_o == 4'hF |=> skip_o)
        else $error("wrap did not arm the skip");

    AST_WRAP_VALUE: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && is_incy && y_ptr_o == 4'hF |=> y_ptr_o == PIY_Y_ZERO)
        else $error("y pointer did not wrap to zero");

    AST_SKIP_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
        insn_valid_i && skip_o |=> !skip_o)
        else $error("skip not retired by the skipped slot");

    AST_SKIP_Y: assert property (@(posedge mclk_i) disable iff (rst_i)
        insn_valid_i && skip_o |=> $stable(y_ptr_o))
        else $error("skipped slot changed the y pointer");

    AST_SKIP_ACC: assert property (@(posedge mclk_i) disable iff (rst_i)
        insn_valid_i && skip_o |=> $stable(acc_o))
        else $error("skipped slot changed the accumulator");

    AST_SKIP_IDLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        !insn_valid_i |=> $stable(skip_o))
        else $error("skip changed in an empty cycle");

    AST_SKIP_CAUSE: assert property (@(posedge mclk_i) disable iff (rst_i)
        !skip_o && !(exec && is_incy && y_ptr_o == 4'hF) |=> !skip_o)
        else $error("skip raised without a wrap");

    AST_Y_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !(exec && is_incy) |=> $stable(y_ptr_o))
        else $error("y pointer changed without an increment");

    AST_INCY_ACC: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && is_incy |=> $stable(acc_o))
        else $error("increment disturbed the accumulator");

    AST_READ_Y: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && is_read |=> $stable(y_ptr_o) && !skip_o)
        else $error("port read disturbed the y pointer or skip");

    AST_UNKNOWN_OP: assert property (@(posedge mclk_i) disable iff (rst_i)
        exec && !is_read && !is_incy |=> $stable(acc_o) && $stable(y_ptr_o) && !skip_o)
        else $error("foreign opcode changed local state");

    AST_IDLE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !insn_valid_i |=> $stable(acc_o) && $stable(y_ptr_o))
        else $error("state changed in an empty cycle");

    AST_RESET: assert property (@(posedge mclk_i)
        rst_i |=> acc_o == PIY_ACC_RST && y_ptr_o == PIY_Y_RST && !skip_o)
        else $error("state not cleared by reset");

    COV_WRAP: cover property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_INCY && y_ptr_o == 4'hF);

    COV_SKIPPED: cover property (@(posedge mclk_i) disable iff (rst_i)
        skip_o && insn_valid_i && insn_i == PIY_OP_RDP0);

    COV_READ4: cover property (@(posedge mclk_i) disable iff (rst_i)
        exec && insn_i == PIY_OP_RDP4);

    COV_STEP_READ: cover property (@(posedge mclk_i) disable iff (rst_i)
        exec && is_incy && y_ptr_o != 4'hF ##1 exec && is_read);

    COV_IDLE_SKIP: cover property (@(posedge mclk_i) disable iff (rst_i)
        skip_o && !insn_valid_i);
endmodule
`default_nettype wire

// >>> piy_port_src.sv
// partner model: levels applied to the five input ports
`timescale 1ns/100ps
`default_nettype none
module piy_port_src
    import piy_pkg::*;
(
    input  wire logic [PIY_NIB_W-1:0] base_i,
    output logic      [PIY_NIB_W-1:0] port_zero_o,
    output logic      [PIY_NIB_W-1:0] port_one_o,
    output logic      [PIY_NIB_W-1:0] port_two_o,
    output logic      [PIY_NIB_W-1:0] port_three_o,
    output logic      [PIY_NIB_W-1:0] port_four_o
);
    // distinct level per port so a wrong port select shows up
    assign port_zero_o  = base_i ^ 4'h1;
    assign port_one_o   = base_i ^ 4'h2;
    assign port_two_o   = base_i ^ 4'h3;
    assign port_three_o = base_i ^ 4'h4;
    assign port_four_o  = base_i ^ 4'h5;
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the port-input and y-increment decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
    import piy_pkg::*;
    logic                 mclk_i = 0;
    logic                 rst_i = 1;
    logic                 vld = 0;
    logic [9:0]           insn = 0;
    logic [3:0]           base = 0;
    logic [3:0]           prt_zero;
    logic [3:0]           prt_one;
    logic [3:0]           prt_two;
    logic [3:0]           prt_three;
    logic [3:0]           prt_four;
    logic [3:0]           acc, yp;
    logic                 skp;
    int                   failures = 0;
    int                   total_checks = 0;
    always #2 mclk_i = ~mclk_i;
    piy_port_src SRC (.base_i(base), .port_zero_o(prt_zero), .port_one_o(prt_one),
        .port_two_o(prt_two), .port_three_o(prt_three), .port_four_o(prt_four));
    piy_decoder DUT (.mclk_i(mclk_i), .rst_i(rst_i), .insn_valid_i(vld), .insn_i(insn),
        .input_port_zero_i(prt_zero), .input_port_one_i(prt_one), .input_port_two_i(prt_two),
        .input_port_three_i(prt_three), .input_port_four_i(prt_four),
        .acc_o(acc), .y_ptr_o(yp), .skip_o(skp));
    // one slot per call; valid stays up so calls run back to back
    task automatic step(input logic [9:0] op);
        vld = 1;
        insn = op;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic t_read();
        for (int k = 0; k < 5; k++) begin
            base = 4'(k * 4);
            step(PIY_OP_RDP0 + 10'(k));
            `CHK(acc, 4'(k * 4) ^ 4'(k + 1))
        end
    endtask
    task automatic t_incy();
        base = 4'h9;
        for (int i = 1; i < 16; i++) begin
            step(PIY_OP_INCY);
            `CHK({yp, skp}, {4'(i), 1'b0})
        end
        step(PIY_OP_INCY);
        `CHK({yp, skp}, 5'h01)
        step(PIY_OP_RDP0);
        `CHK({acc, yp, skp}, 9'h0A0)
        step(PIY_OP_INCY);
        step(PIY_OP_RDP1);
        `CHK({acc, yp}, 8'hB1)
        vld = 0;
    endtask
    // empty cycles and foreign opcodes leave state alone; a skip waits for a slot
    task automatic t_hold();
        insn = PIY_OP_RDP2;
        @(posedge mclk_i);
        #1;
        `CHK({acc, yp, skp}, 9'h162)
        step(10'h000);
        `CHK({acc, yp, skp}, 9'h162)
        for (int i = 2; i < 17; i++) begin
            step(PIY_OP_INCY);
        end
        `CHK({yp, skp}, 5'h01)
        vld = 0;
        @(posedge mclk_i);
        #1;
        `CHK(skp, 1'b1)
        step(PIY_OP_RDP2);
        `CHK({acc, yp, skp}, 9'h160)
        vld = 0;
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // about 55 cycles are needed, reset included; far longer means a hang
    initial begin
        #2000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        #1;
        rst_i = 0;
        `CHK({acc, yp, skp}, 9'h000)
        t_read();
        t_incy();
        t_hold();
        give_verdict();
    end
endmodule
`default_nettype wire
